// ### hw/hmsq_pkg.sv
// Constants, register map and types for the hardware monitor sequencer
package hmsq_pkg;
	// ----------------------------------------
	// Channels
	// ----------------------------------------
	localparam int NUM_CH = 8;
	localparam logic [2:0] CH_FIRST = 3'h0;
	localparam logic [2:0] CH_REMOTE = 3'h6;
	localparam logic [2:0] CH_LOCAL = 3'h7;
	// Temperature channels compare signed
	localparam logic [7:0] SIGNED_CH_MASK = 8'hC0;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_VALUE_BASE = 8'h20;
	localparam logic [7:0] ADDR_LOCAL_VALUE = 8'h27;
	localparam logic [7:0] ADDR_LIMIT_BASE = 8'h2B;
	localparam logic [7:0] LIMIT_SPAN = 8'h10;
	localparam logic [7:0] VALUE_SPAN = 8'h08;
	localparam logic [7:0] ADDR_CONFIG = 8'h40;
	localparam logic [7:0] ADDR_STATUS_FIRST = 8'h41;
	localparam logic [7:0] ADDR_STATUS_SECOND = 8'h42;
	localparam int CFG_START_BIT = 0;
	localparam int ST1_LOCAL_BIT = 5;
	localparam int ST1_REMOTE_BIT = 6;
	localparam int ST2_VCC_BIT = 0;
	localparam int ST2_FAULT_BIT = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam real CLK_HZ = 20000000.0;
	localparam real CONV_PERIOD_MS = 11.6;
	localparam real REMOTE_PERIOD_MS = 34.8;
	localparam int SAMPLES_PER_REMOTE = 16;
	localparam logic [3:0] LAST_SAMPLE = 4'hF;
	localparam int CONV_CYCLES = int'(CONV_PERIOD_MS * CLK_HZ / 1000.0);
	localparam int SAMPLE_CYCLES = int'(REMOTE_PERIOD_MS * CLK_HZ / 1000.0) / SAMPLES_PER_REMOTE;
	// Fixed overhead cycles of the slot loop
	localparam int CONV_OVERHEAD = 4;
	localparam int SAMPLE_OVERHEAD = 2;
	localparam int TIMER_W = 18;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_START = 6'h02,
		ST_WAIT = 6'h04,
		ST_PACE = 6'h08,
		ST_STORE = 6'h10,
		ST_CHECK = 6'h20
	} hmsq_state_t;
endpackage

// ### hw/hmsq_limit_cmp.sv
// Window comparator of one channel result against its limits
`timescale 1ns/10ps
module hmsq_limit_cmp #(
	parameter bit SIGNED_CMP = 1'b0
) (
	input wire logic [7:0] i_value,
	input wire logic [7:0] i_high,
	input wire logic [7:0] i_low,
	output logic o_out_of_limit
);
	// Strictly outside counts; equal to a limit is in range
	always_comb begin
		if (SIGNED_CMP) begin
			o_out_of_limit = ($signed(i_value) > $signed(i_high)) || ($signed(i_value) < $signed(i_low));
		end else begin
			o_out_of_limit = (i_value > i_high) || (i_value < i_low);
		end
	end
endmodule

// ### hw/hmsq_sequencer.sv
// Monitoring sequencer, averaging, limit checking and registers
//
// Notes on behaviour
// - Local temperature result stored at 27h
// - Codes are signed whole degrees, -128..127
// - Diode fault sets bit 6 at 42h
// - Anode shorts and pair short/open flag fault
// - Remote result averages sixteen raw samples
// - Remote measurement takes nominally 34.8 ms
// - Each channel compared against own limits
// - Status bit 0 inside, 1 outside
// - Status shows only latest comparison
// - Reading status leaves it unchanged
// - Config bit 0 set starts monitoring
// - Each input converted and stored in turn
// - Sequence repeats until config bit cleared
// - Value registers readable anytime, latest result
// - Out-of-limit results drive alert indications
// - Other inputs converted every 11.6 ms
// - Conversion results are eight bits
// - Reset clears registers, converter stays idle
`timescale 1ns/10ps
module hmsq_sequencer
	import hmsq_pkg::*;
#(
	parameter int P_CONV_CYCLES = CONV_CYCLES,
	parameter int P_SAMPLE_CYCLES = SAMPLE_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	output logic o_conv_start,
	output logic [2:0] o_conv_channel,
	input wire logic i_conv_done,
	input wire logic [7:0] i_conv_data,
	input wire logic i_diode_anode_gnd,
	input wire logic i_diode_anode_supply,
	input wire logic i_diode_pair_fault,
	output logic o_temp_alert,
	output logic o_volt_alert,
	output logic o_monitor_active
);
	localparam logic [TIMER_W-1:0] CONV_LOAD = TIMER_W'(P_CONV_CYCLES - CONV_OVERHEAD);
	localparam logic [TIMER_W-1:0] SAMPLE_LOAD = TIMER_W'(P_SAMPLE_CYCLES - SAMPLE_OVERHEAD);

	// ----------------------------------------
	// Fault input synchronisers
	// ----------------------------------------
	logic [2:0] fault_meta;
	logic [2:0] fault_sync;
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			fault_meta <= 3'h0;
			fault_sync <= 3'h0;
		end else begin
			fault_meta <= {i_diode_pair_fault, i_diode_anode_supply, i_diode_anode_gnd};
			fault_sync <= fault_meta;
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	hmsq_state_t state, next_state;
	logic [2:0] chan, next_chan;
	logic [TIMER_W-1:0] timer, next_timer;
	logic [3:0] sample_cnt, next_sample_cnt;
	logic [11:0] acc, next_acc;
	logic [7:0] sample, next_sample;
	logic fault_seen, next_fault_seen;
	logic diode_fault, next_diode_fault;
	logic [7:0] value [NUM_CH];
	logic [7:0] next_value [NUM_CH];
	logic [7:0] oor, next_oor;
	logic conv_start, next_conv_start;
	logic temp_alert, next_temp_alert;
	logic volt_alert, next_volt_alert;
	logic active, next_active;
	logic run, next_run;
	logic [7:0] limit_hi [NUM_CH];
	logic [7:0] limit_lo [NUM_CH];
	logic [7:0] next_limit_hi [NUM_CH];
	logic [7:0] next_limit_lo [NUM_CH];
	logic [7:0] rdata, next_rdata;
	logic [7:0] cmp_out;
	logic is_remote;

	assign is_remote = (chan == CH_REMOTE);

	// ----------------------------------------
	// Limit comparators
	// ----------------------------------------
	for (genvar g = 0; g < NUM_CH; g++) begin : g_cmp
		hmsq_limit_cmp #(
			.SIGNED_CMP(SIGNED_CH_MASK[g])
		) u_cmp (
			.i_value(value[g]),
			.i_high(limit_hi[g]),
			.i_low(limit_lo[g]),
			.o_out_of_limit(cmp_out[g])
		);
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_chan = chan;
		next_timer = (timer != '0) ? timer - 1'b1 : timer;
		next_sample_cnt = sample_cnt;
		next_acc = acc;
		next_sample = sample;
		next_fault_seen = fault_seen | (is_remote & (|fault_sync));
		next_diode_fault = diode_fault;
		next_value = value;
		next_oor = oor;
		next_conv_start = 1'b0;
		case (state)
			ST_IDLE: begin
				if (run) begin
					next_state = ST_START;
					next_chan = CH_FIRST;
					next_sample_cnt = 4'h0;
					next_acc = 12'h000;
					next_fault_seen = 1'b0;
				end
			end
			ST_START: begin
				next_conv_start = 1'b1;
				next_timer = is_remote ? SAMPLE_LOAD : CONV_LOAD;
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (i_conv_done) begin
					next_sample = i_conv_data;
					if (is_remote) begin
						next_acc = acc + {{4{i_conv_data[7]}}, i_conv_data};
					end
					next_state = ST_PACE;
				end
			end
			ST_PACE: begin
				if (timer == '0) begin
					if (is_remote && (sample_cnt != LAST_SAMPLE)) begin
						next_sample_cnt = sample_cnt + 4'h1;
						next_state = ST_START;
					end else begin
						next_state = ST_STORE;
					end
				end
			end
			ST_STORE: begin
				// Arithmetic shift keeps the signed whole-degree code
				next_value[chan] = is_remote ? acc[11:4] : sample;
				next_state = ST_CHECK;
			end
			ST_CHECK: begin
				next_oor[chan] = cmp_out[chan];
				if (is_remote) begin
					// Fault seen in the closing cycle still counts
					next_diode_fault = fault_seen | (|fault_sync);
				end
				next_chan = chan + 3'h1;
				next_sample_cnt = 4'h0;
				next_acc = 12'h000;
				next_fault_seen = 1'b0;
				// Stop is honoured only between conversions
				next_state = run ? ST_START : ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_temp_alert = oor[CH_REMOTE] | oor[CH_LOCAL];
		next_volt_alert = |oor[5:0];
		next_active = (next_state != ST_IDLE);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= ST_IDLE;
			chan <= CH_FIRST;
			timer <= '0;
			sample_cnt <= 4'h0;
			acc <= 12'h000;
			sample <= RESET_BYTE;
			fault_seen <= 1'b0;
			diode_fault <= 1'b0;
			value <= '{default: RESET_BYTE};
			oor <= 8'h00;
			conv_start <= 1'b0;
			temp_alert <= 1'b0;
			volt_alert <= 1'b0;
			active <= 1'b0;
		end else begin
			state <= next_state;
			chan <= next_chan;
			timer <= next_timer;
			sample_cnt <= next_sample_cnt;
			acc <= next_acc;
			sample <= next_sample;
			fault_seen <= next_fault_seen;
			diode_fault <= next_diode_fault;
			value <= next_value;
			oor <= next_oor;
			conv_start <= next_conv_start;
			temp_alert <= next_temp_alert;
			volt_alert <= next_volt_alert;
			active <= next_active;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] val_off;
	logic [7:0] lim_off;
	logic [7:0] status_first;
	logic [7:0] status_second;
	logic [7:0] rd_mux;

	always_comb begin
		val_off = i_reg_addr - ADDR_VALUE_BASE;
		lim_off = i_reg_addr - ADDR_LIMIT_BASE;
		status_first = 8'h00;
		status_first[4:0] = oor[4:0];
		status_first[ST1_LOCAL_BIT] = oor[CH_LOCAL];
		status_first[ST1_REMOTE_BIT] = oor[CH_REMOTE];
		status_second = 8'h00;
		status_second[ST2_VCC_BIT] = oor[5];
		status_second[ST2_FAULT_BIT] = diode_fault;
		rd_mux = 8'h00;
		if (val_off < VALUE_SPAN) begin
			rd_mux = value[val_off[2:0]];
		end else if (lim_off < LIMIT_SPAN) begin
			rd_mux = lim_off[0] ? limit_lo[lim_off[3:1]] : limit_hi[lim_off[3:1]];
		end else if (i_reg_addr == ADDR_CONFIG) begin
			rd_mux = {7'h00, run};
		end else if (i_reg_addr == ADDR_STATUS_FIRST) begin
			rd_mux = status_first;
		end else if (i_reg_addr == ADDR_STATUS_SECOND) begin
			rd_mux = status_second;
		end
	end

	always_comb begin
		next_run = run;
		next_limit_hi = limit_hi;
		next_limit_lo = limit_lo;
		next_rdata = rdata;
		if (i_reg_wr) begin
			if (i_reg_addr == ADDR_CONFIG) begin
				next_run = i_reg_wdata[CFG_START_BIT];
			end else if (lim_off < LIMIT_SPAN) begin
				if (lim_off[0]) begin
					next_limit_lo[lim_off[3:1]] = i_reg_wdata;
				end else begin
					next_limit_hi[lim_off[3:1]] = i_reg_wdata;
				end
			end
		end
		// Reads load only rdata and have no side effect on any other register
		if (i_reg_rd) begin
			next_rdata = rd_mux;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			run <= 1'b0;
			limit_hi <= '{default: RESET_BYTE};
			limit_lo <= '{default: RESET_BYTE};
			rdata <= RESET_BYTE;
		end else begin
			run <= next_run;
			limit_hi <= next_limit_hi;
			limit_lo <= next_limit_lo;
			rdata <= next_rdata;
		end
	end

	assign o_reg_rdata = rdata;
	assign o_conv_start = conv_start;
	assign o_conv_channel = chan;
	assign o_temp_alert = temp_alert;
	assign o_volt_alert = volt_alert;
	assign o_monitor_active = active;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	sequence s_start_pulse;
		o_conv_start ##1 !o_conv_start;
	endsequence

	sequence s_store_check;
		(state == ST_STORE) ##1 (state == ST_CHECK);
	endsequence

	a_conv_start_pulse: assert property ((state == ST_START) |=> s_start_pulse)
		else $error("conversion start not a single pulse");

	a_local_store: assert property ((state == ST_STORE) && (chan == CH_LOCAL)
		|=> value[CH_LOCAL] == $past(sample))
		else $error("local result not stored");

	a_remote_avg: assert property ((state == ST_STORE) && is_remote
		|=> (value[CH_REMOTE] == $past(acc[11:4])) && ($past(sample_cnt) == LAST_SAMPLE))
		else $error("remote average wrong");

	a_fault_bit: assert property ((state == ST_CHECK) && is_remote
		|=> diode_fault == $past(fault_seen | (|fault_sync)))
		else $error("diode fault bit not updated");

	a_status_update: assert property ((state == ST_PACE) && (timer == '0) && !is_remote
		|=> s_store_check ##1 (oor[$past(chan)] == $past(cmp_out[chan])))
		else $error("status bit not updated from compare");

	a_status_read: assert property (i_reg_rd && (state != ST_CHECK)
		|=> $stable(oor) && $stable(diode_fault))
		else $error("status changed on read");

	a_value_read: assert property (i_reg_rd && (i_reg_addr == ADDR_LOCAL_VALUE)
		|=> o_reg_rdata == $past(value[CH_LOCAL]))
		else $error("value read mismatch");

	a_idle_hold: assert property ((state == ST_IDLE) && !run |=> (state == ST_IDLE) && !o_conv_start)
		else $error("converter left idle without start");

	a_stop_effect: assert property ((state == ST_CHECK) && !run |=> (state == ST_IDLE) ##1 !o_monitor_active)
		else $error("stop not honoured after conversion");

	a_slot_pace: assert property ((state == ST_PACE) && (timer != '0) |=> state == ST_PACE)
		else $error("slot left before its time");

	a_alert_source: assert property ((state == ST_CHECK) && cmp_out[chan] && !is_remote && (chan != CH_LOCAL)
		|-> ##2 o_volt_alert)
		else $error("voltage alert missing");
endmodule

// ### verification/hmsq_conv_model.sv
// Behavioural converter answering the sequencer's start requests
`timescale 1ns/10ps
module hmsq_conv_model #(
	parameter int P_DELAY = 3
) (
	input wire logic i_clk,
	input wire logic i_conv_start,
	input wire logic [2:0] i_conv_channel,
	input wire logic [63:0] i_codes,
	output logic o_conv_done,
	output logic [7:0] o_conv_data
);
	logic [3:0] cnt = 4'h0;
	logic [2:0] ch = 3'h0;
	logic flip = 1'b0;
	logic [7:0] val;

	// Remote samples alternate +2 / -1 so the average exercises floor rounding
	always_comb begin
		val = i_codes[ch*8+:8];
		if (ch == 3'h6) begin
			val = flip ? val - 8'h01 : val + 8'h02;
		end
	end

	always @(posedge i_clk) begin
		if (i_conv_start) begin
			cnt <= 4'(P_DELAY);
			ch <= i_conv_channel;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
		if (cnt == 4'h1 && ch == 3'h6) begin
			flip <= ~flip;
		end
	end

	assign o_conv_done = (cnt == 4'h1);
	// Data not valid outside done: show the inverse, never a stale value
	assign o_conv_data = o_conv_done ? val : ~val;
endmodule

// ### verification/hw_monitor_sequencer_test.sv
// Self-checking testbench of the monitoring sequencer
`timescale 1ns/10ps
module hw_monitor_sequencer_test;
	import hmsq_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic start, done, t_alert, v_alert, active;
	logic [2:0] chan;
	logic [7:0] cdata;
	logic [2:0] flt = 3'h0;
	logic [63:0] codes = 64'hF6EC05FF1110C1C0;
	localparam int TB_CONV = 20;
	localparam int TB_SAMPLE = 10;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;

	always #25 i_clk = ~i_clk;

	hmsq_sequencer #(.P_CONV_CYCLES(TB_CONV), .P_SAMPLE_CYCLES(TB_SAMPLE)) i_hmsq_sequencer (
		.i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .o_conv_start(start), .o_conv_channel(chan),
		.i_conv_done(done), .i_conv_data(cdata), .i_diode_anode_gnd(flt[0]),
		.i_diode_anode_supply(flt[1]), .i_diode_pair_fault(flt[2]), .o_temp_alert(t_alert),
		.o_volt_alert(v_alert), .o_monitor_active(active));

	hmsq_conv_model i_hmsq_conv_model (
		.i_clk(i_clk), .i_conv_start(start), .i_conv_channel(chan), .i_codes(codes),
		.o_conv_done(done), .o_conv_data(cdata));

	task automatic final_report();
		if (n_fail == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge i_clk);
		wr = 1'b0;
	endtask

	task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge i_clk);
		addr = a;
		rd = 1'b1;
		@(negedge i_clk);
		rd = 1'b0;
		chk(rdata, exp);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_state();
		for (int i = 0; i < 8; i++) begin
			reg_chk(ADDR_VALUE_BASE + 8'(i), RESET_BYTE);
			reg_chk(ADDR_LIMIT_BASE + 8'(2 * i), RESET_BYTE);
			reg_chk(ADDR_LIMIT_BASE + 8'(2 * i + 1), RESET_BYTE);
		end
		reg_chk(ADDR_CONFIG, RESET_BYTE);
		reg_chk(ADDR_STATUS_FIRST, RESET_BYTE);
		reg_chk(ADDR_STATUS_SECOND, RESET_BYTE);
		chk({7'h00, active}, 8'h00);
	endtask

	// Mixed in/out cases, limit-equal boundaries, signed temperatures
	task automatic t_first_pass();
		logic [63:0] hi;
		logic [63:0] lo;
		hi = 64'h1900FF80FFFFC0C0;
		lo = 64'hECF6050011110000;
		for (int i = 0; i < 8; i++) begin
			reg_wr(ADDR_LIMIT_BASE + 8'(2 * i), hi[i*8+:8]);
			reg_wr(ADDR_LIMIT_BASE + 8'(2 * i + 1), lo[i*8+:8]);
		end
		reg_wr(ADDR_CONFIG, 8'h01);
		repeat (800) @(negedge i_clk);
		chk({7'h00, active}, 8'h01);
		reg_chk(ADDR_CONFIG, 8'h01);
		for (int i = 0; i < 8; i++) begin
			reg_chk(ADDR_VALUE_BASE + 8'(i), codes[i*8+:8]);
		end
		reg_chk(ADDR_LOCAL_VALUE, 8'hF6);
		reg_chk(ADDR_STATUS_FIRST, 8'h56);
		reg_chk(ADDR_STATUS_FIRST, 8'h56);
		reg_chk(ADDR_STATUS_SECOND, 8'h00);
		chk({6'h00, t_alert, v_alert}, 8'h03);
	endtask

	// Same limits, results moved inside: status must clear
	task automatic t_recover();
		@(negedge i_clk);
		codes = 64'hF6F605801111C0C0;
		repeat (800) @(negedge i_clk);
		reg_chk(ADDR_VALUE_BASE + 8'h06, 8'hF6);
		reg_chk(ADDR_STATUS_FIRST, 8'h00);
		chk({6'h00, t_alert, v_alert}, 8'h00);
	endtask

	// Start spacing per slot, remote sample count and channel order
	task automatic t_pacing();
		int gap;
		int n_rem;
		int n;
		n = 0;
		while (!(start === 1'b1 && chan === CH_FIRST) && n < 1000) begin
			@(negedge i_clk);
			n++;
		end
		gap = 0;
		do begin
			@(negedge i_clk);
			gap++;
		end while (start !== 1'b1 && gap < 1000);
		chk(8'(gap), 8'(TB_CONV));
		chk({5'h00, chan}, 8'h01);
		n = 0;
		while (!(start === 1'b1 && chan === CH_REMOTE) && n < 1000) begin
			@(negedge i_clk);
			n++;
		end
		n_rem = 1;
		repeat (SAMPLES_PER_REMOTE - 1) begin
			gap = 0;
			do begin
				@(negedge i_clk);
				gap++;
			end while (start !== 1'b1 && gap < 1000);
			chk(8'(gap), 8'(TB_SAMPLE));
			if (chan === CH_REMOTE) begin
				n_rem++;
			end
		end
		chk(8'(n_rem), 8'(SAMPLES_PER_REMOTE));
		gap = 0;
		do begin
			@(negedge i_clk);
			gap++;
		end while (start !== 1'b1 && gap < 1000);
		chk({5'h00, chan}, {5'h00, CH_LOCAL});
	endtask

	task automatic t_faults();
		for (int i = 0; i < 3; i++) begin
			@(negedge i_clk);
			flt = 3'(1 << i);
			repeat (800) @(negedge i_clk);
			reg_chk(ADDR_STATUS_SECOND, 8'h40);
			@(negedge i_clk);
			flt = 3'h0;
			repeat (800) @(negedge i_clk);
			reg_chk(ADDR_STATUS_SECOND, 8'h00);
		end
	endtask

	task automatic t_stop();
		int n;
		reg_wr(ADDR_CONFIG, 8'h00);
		n = 0;
		while (active === 1'b1 && n < 1000) begin
			@(negedge i_clk);
			n++;
		end
		chk({7'h00, active}, 8'h00);
		n = 0;
		repeat (200) begin
			@(negedge i_clk);
			if (start !== 1'b0) begin
				n++;
			end
		end
		chk(8'(n), 8'h00);
		reg_wr(ADDR_LOCAL_VALUE, 8'h55);
		reg_chk(ADDR_LOCAL_VALUE, 8'hF6);
		reg_chk(8'hFF, 8'h00);
	endtask

	initial begin
		repeat (5) @(negedge i_clk);
		i_reset = 1'b0;
		t_reset_state();
		t_first_pass();
		t_recover();
		t_pacing();
		t_faults();
		t_stop();
		final_report();
	end
endmodule
